// >>> src/icdac_defs.svh
// Constants of the current DAC control block: addresses, fields, resets, bit counts
`ifndef ICDAC_DEFS_SVH
`define ICDAC_DEFS_SVH

// Target address byte with both straps low; straps fill bits 6 and 7
`define ICDAC_ADDR_BASE 8'h20
`define ICDAC_STRAP_LOW_POS 6
`define ICDAC_STRAP_HIGH_POS 7

// Channel setting locations, one per channel in ascending order
`define ICDAC_REG_CH0 8'hf8
`define ICDAC_REG_CH1 8'hf9
`define ICDAC_REG_CH2 8'hfa
`define ICDAC_REG_CH3 8'hfb
`define ICDAC_NUM_CH 4
`define ICDAC_NUM_CH_SMALL 2

// Channel setting fields and reset values
`define ICDAC_SIGN_POS 7
`define ICDAC_CODE_MSB 6
`define ICDAC_CODE_RESET 8'h00
`define ICDAC_CODE_ZERO 7'h00
`define ICDAC_CODE_FULL 7'h7f
`define ICDAC_PTR_RESET 8'h00

// Bit counting inside one byte plus acknowledge slot
`define ICDAC_LAST_DATA_BIT 4'h7
`define ICDAC_ACK_SLOT 4'h8

`endif

// >>> src/icdac_pkg.sv
// Types shared by the current DAC control block
`default_nettype none
package icdac_pkg;

	// Protocol state of the serial target
	typedef enum logic [2:0] {
		ICDAC_ST_IDLE,
		ICDAC_ST_ADDR,
		ICDAC_ST_REG,
		ICDAC_ST_DATA,
		ICDAC_ST_READ,
		ICDAC_ST_IGNORE
	} icdac_state_e;

	// Drive handed to one analog current generator
	typedef struct packed {
		logic sink_on;
		logic source_on;
		logic [6:0] magnitude_code;
	} icdac_drive_s;

endpackage
`default_nettype wire

// >>> src/icdac_ctrl.sv
// Current DAC control: serial bus target, channel setting registers, output drive
`timescale 1ns/1ps
`default_nettype none
`include "icdac_defs.svh"
module icdac_ctrl
#(
	parameter bit FOUR_CH = 1'b1
)
(
	// System clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Serial bus clock, the link domain
	input wire logic i_scl,
	// Serial data pin, open drain
	input wire logic i_sda_i,
	output logic o_sda_o,
	output logic o_sda_oe,
	// Address straps
	input wire logic i_addr_strap_low,
	input wire logic i_addr_strap_high,
	// Drive to the analog current generators and bus status
	output var icdac_pkg::icdac_drive_s [`ICDAC_NUM_CH-1:0] o_drive,
	output logic o_bus_idle
);
	import icdac_pkg::*;

	// Link domain: bits shifted in on SCL rise, toggle marks each rise
	logic [7:0] link_bits;
	logic link_tgl;
	logic [7:0] next_link_bits;
	logic next_link_tgl;

	// Synchronisers: toggle, scl, sda, strap high, strap low
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] next_sync1;
	logic [4:0] next_sync2;
	logic tgl_d;
	logic scl_d;
	logic sda_d;
	logic next_tgl_d;
	logic next_scl_d;
	logic next_sda_d;

	// Protocol state
	icdac_state_e state;
	icdac_state_e next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic [7:0] tx_byte;
	logic [7:0] next_tx_byte;
	logic ack_en;
	logic next_ack_en;
	logic sda_oe;
	logic next_sda_oe;
	logic bus_idle;
	logic next_bus_idle;

	// Decoded events and register access
	logic rise_ev;
	logic fall_ev;
	logic start_ev;
	logic stop_ev;
	logic [7:0] addr_byte;
	logic wr_strobe;
	logic [7:0] rd_val;
	logic [7:0] ch_code [`ICDAC_NUM_CH];
	logic [7:0] rd_term [`ICDAC_NUM_CH];

	// Link side shift; SDA is stable through SCL high, so rise sampling is safe
	always_comb
	begin
		next_link_bits = {link_bits[6:0], i_sda_i};
		next_link_tgl = ~link_tgl;
	end

	// Link side registers; the toggle carries each rise across to the system clock
	always_ff @(posedge i_scl or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			link_bits <= 8'h00;
			link_tgl <= 1'b0;
		end
		else
		begin
			link_bits <= next_link_bits;
			link_tgl <= next_link_tgl;
		end
	end

	// Two-stage synchronisers, then one delay stage for edge detection
	always_comb
	begin
		next_sync1 = {link_tgl, i_scl, i_sda_i, i_addr_strap_high, i_addr_strap_low};
		next_sync2 = sync1;
		next_tgl_d = sync2[4];
		next_scl_d = sync2[3];
		next_sda_d = sync2[2];
	end

	// Synchroniser registers
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			// Toggle low like link_tgl, lines high: no false edge after reset
			sync1 <= 5'h0c;
			sync2 <= 5'h0c;
			tgl_d <= 1'b0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			tgl_d <= next_tgl_d;
			scl_d <= next_scl_d;
			sda_d <= next_sda_d;
		end
	end

	// Bus events; link_bits is stable for a whole SCL period after each toggle
	assign rise_ev = sync2[4] ^ tgl_d;
	assign fall_ev = scl_d & ~sync2[3];
	assign start_ev = scl_d & sync2[3] & sda_d & ~sync2[2];
	assign stop_ev = scl_d & sync2[3] & ~sda_d & sync2[2];

	// Own address from the straps
	always_comb
	begin
		addr_byte = `ICDAC_ADDR_BASE;
		addr_byte[`ICDAC_STRAP_LOW_POS] = sync2[0];
		addr_byte[`ICDAC_STRAP_HIGH_POS] = sync2[1];
	end

	// Read data: implemented channels contribute, anything else reads zero
	always_comb
	begin
		rd_val = 8'h00;
		for (int k = 0; k < `ICDAC_NUM_CH; k++)
		begin
			rd_val = rd_val | rd_term[k];
		end
	end

	// Protocol sequencer; start and stop override any bit in progress
	always_comb
	begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_ptr = ptr;
		next_tx_byte = tx_byte;
		next_ack_en = ack_en;
		next_sda_oe = sda_oe;
		next_bus_idle = bus_idle;
		wr_strobe = 1'b0;
		if (start_ev)
		begin
			// Repeated start takes the same path as a fresh one
			next_state = ICDAC_ST_ADDR;
			next_bit_cnt = 4'h0;
			next_ack_en = 1'b0;
			next_sda_oe = 1'b0;
			next_bus_idle = 1'b0;
		end
		else if (stop_ev)
		begin
			next_state = ICDAC_ST_IDLE;
			next_bit_cnt = 4'h0;
			next_ack_en = 1'b0;
			next_sda_oe = 1'b0;
			next_bus_idle = 1'b1;
		end
		else if (rise_ev && state != ICDAC_ST_IDLE && state != ICDAC_ST_IGNORE)
		begin
			if (bit_cnt == `ICDAC_ACK_SLOT)
			begin
				// Acknowledge slot done; a high level in a read is the final NACK
				next_bit_cnt = 4'h0;
				next_ack_en = 1'b0;
				if (state == ICDAC_ST_READ && link_bits[0])
				begin
					next_state = ICDAC_ST_IGNORE;
				end
			end
			else
			begin
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == `ICDAC_LAST_DATA_BIT)
				begin
					case (state)
						ICDAC_ST_ADDR:
						begin
							if (link_bits[7:1] == addr_byte[7:1])
							begin
								next_ack_en = 1'b1;
								if (link_bits[0])
								begin
									next_state = ICDAC_ST_READ;
									next_tx_byte = rd_val;
								end
								else
								begin
									next_state = ICDAC_ST_REG;
								end
							end
							else
							begin
								next_state = ICDAC_ST_IGNORE;
							end
						end
						ICDAC_ST_REG:
						begin
							next_ptr = link_bits;
							next_ack_en = 1'b1;
							next_state = ICDAC_ST_DATA;
						end
						ICDAC_ST_DATA:
						begin
							// Whole byte in hand before the setting changes
							wr_strobe = 1'b1;
							next_ack_en = 1'b1;
						end
						default:
						begin
							next_state = state;
						end
					endcase
				end
			end
		end
		else if (fall_ev)
		begin
			// Pin changes only in SCL low, one fall before the rise that samples it
			if (state == ICDAC_ST_IDLE || state == ICDAC_ST_IGNORE)
			begin
				next_sda_oe = 1'b0;
			end
			else if (bit_cnt == `ICDAC_ACK_SLOT)
			begin
				next_sda_oe = ack_en;
			end
			else if (state == ICDAC_ST_READ)
			begin
				next_sda_oe = ~tx_byte[3'h7 - bit_cnt[2:0]];
			end
			else
			begin
				next_sda_oe = 1'b0;
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state <= ICDAC_ST_IDLE;
			bit_cnt <= 4'h0;
			ptr <= `ICDAC_PTR_RESET;
			tx_byte <= 8'h00;
			ack_en <= 1'b0;
			sda_oe <= 1'b0;
			bus_idle <= 1'b1;
		end
		else
		begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			ptr <= next_ptr;
			tx_byte <= next_tx_byte;
			ack_en <= next_ack_en;
			sda_oe <= next_sda_oe;
			bus_idle <= next_bus_idle;
		end
	end

	// Open drain: only ever pulls low
	assign o_sda_o = 1'b0;
	assign o_sda_oe = sda_oe;
	assign o_bus_idle = bus_idle;

	// Per channel setting register and analog drive
	for (genvar i = 0; i < `ICDAC_NUM_CH; i++)
	begin : g_ch
		localparam bit IMPL = FOUR_CH || (i < `ICDAC_NUM_CH_SMALL);
		logic hit;
		logic [7:0] next_code;
		icdac_drive_s drive;
		icdac_drive_s next_drive;

		// Location decode; missing channels never match, so writes fall away
		assign hit = IMPL && (ptr == (`ICDAC_REG_CH0 + 8'(i)));
		assign rd_term[i] = hit ? ch_code[i] : 8'h00;

		// Setting and drive next values
		always_comb
		begin
			next_code = ch_code[i];
			if (wr_strobe && hit)
			begin
				next_code = link_bits;
			end
			// Zero code means no current whatever the sign says
			next_drive.magnitude_code = ch_code[i][`ICDAC_CODE_MSB:0];
			next_drive.source_on = ch_code[i][`ICDAC_SIGN_POS] &&
				(ch_code[i][`ICDAC_CODE_MSB:0] != `ICDAC_CODE_ZERO);
			next_drive.sink_on = !ch_code[i][`ICDAC_SIGN_POS] &&
				(ch_code[i][`ICDAC_CODE_MSB:0] != `ICDAC_CODE_ZERO);
		end

		// Setting and drive registers, cleared at reset so outputs start off
		always_ff @(posedge i_mclk or negedge i_rst_b)
		begin
			if (!i_rst_b)
			begin
				ch_code[i] <= `ICDAC_CODE_RESET;
				drive <= '0;
			end
			else
			begin
				ch_code[i] <= next_code;
				drive <= next_drive;
			end
		end

		assign o_drive[i] = drive;
	end

endmodule // icdac_ctrl
`default_nettype wire

// >>> sim/icdac_ctrl_asserts.sv
// Checker of bus and drive behaviour of the current DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "icdac_defs.svh"
module icdac_ctrl_asserts
(
	// Clocks, reset and bus pins
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda_i,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	input wire logic i_addr_strap_low,
	input wire logic i_addr_strap_high,
	// Block outputs
	input wire icdac_pkg::icdac_drive_s [`ICDAC_NUM_CH-1:0] o_drive,
	input wire logic o_bus_idle
);
	import icdac_pkg::*;
	logic drive_bad;
	// Any channel whose enables disagree with its code
	always_comb
	begin
		drive_bad = 1'b0;
		for (int i = 0; i < `ICDAC_NUM_CH; i++)
			if (((o_drive[i].sink_on | o_drive[i].source_on) != (|o_drive[i].magnitude_code))
				|| (o_drive[i].sink_on & o_drive[i].source_on))
				drive_bad = 1'b1;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// Acknowledge or data bit held for at least eight system clocks
	sequence s_held;
		o_sda_oe [*8];
	endsequence
	sequence s_lines_high;
		i_scl && i_sda_i;
	endsequence
	property p_drive_ok; !drive_bad; endproperty
	a_drive_ok: assert property (p_drive_ok)
		else $error("drive enables disagree with code");
	property p_sda_zero; o_sda_o == 1'b0; endproperty
	a_sda_zero: assert property (p_sda_zero)
		else $error("data pin value not low");
	property p_oe_scl_low; !$stable(o_sda_oe) |-> !i_scl; endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("data drive changed with clock high");
	property p_oe_len; $rose(o_sda_oe) |-> s_held; endproperty
	a_oe_len: assert property (p_oe_len)
		else $error("data drive too short");
	property p_idle_quiet; o_bus_idle |-> !o_sda_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("data driven while bus idle");
	property p_idle_fall; $fell(o_bus_idle) |-> i_scl && !i_sda_i; endproperty
	a_idle_fall: assert property (p_idle_fall)
		else $error("busy without start");
	property p_idle_rise; $rose(o_bus_idle) |-> s_lines_high; endproperty
	a_idle_rise: assert property (p_idle_rise)
		else $error("idle without stop");
	property p_drive_frame; !$stable(o_drive) |-> !o_bus_idle; endproperty
	a_drive_frame: assert property (p_drive_frame)
		else $error("drive changed outside transfer");
	property p_drive_rise; !$stable(o_drive) |-> i_scl; endproperty
	a_drive_rise: assert property (p_drive_rise)
		else $error("drive changed with clock low");
endmodule // icdac_ctrl_asserts
`default_nettype wire

// >>> sim/icdac_host_model.sv
// Bus controller model driving clock and data of the serial bus
`timescale 1ns/1ps
`default_nettype none
module icdac_host_model
(
	// Pacing clock and resolved data wire
	input wire logic i_mclk,
	input wire logic i_sda,
	// Bus clock and data pull-down
	output logic o_scl,
	output logic o_sda_oe
);
	// Idle bus: clock still and high, data released
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	// Data moves only with clock low, sampled mid high
	task automatic put_bit(input logic v, output logic s);
		o_sda_oe = ~v;
		wait_n(5);
		o_scl = 1'b1;
		wait_n(5);
		s = i_sda;
		wait_n(5);
		o_scl = 1'b0;
		wait_n(5);
	endtask
	// Same waveform serves first and repeated start
	task automatic bus_start();
		o_sda_oe = 1'b0;
		wait_n(5);
		o_scl = 1'b1;
		wait_n(10);
		o_sda_oe = 1'b1;
		wait_n(10);
		o_scl = 1'b0;
		wait_n(5);
	endtask
	task automatic bus_stop();
		o_sda_oe = 1'b1;
		wait_n(5);
		o_scl = 1'b1;
		wait_n(10);
		o_sda_oe = 1'b0;
		wait_n(20);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], s);
		put_bit(1'b1, ack);
	endtask
	// Releases data for every bit the device sends
	task automatic get_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(1'b1, b[i]);
		put_bit(nack, s);
	endtask
endmodule // icdac_host_model
`default_nettype wire

// >>> sim/icdac_ctrl_tb.sv
// Testbench of the current DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "icdac_defs.svh"
module icdac_ctrl_tb;
	import icdac_pkg::*;
	logic i_mclk;
	logic i_rst_b;
	logic strap_low;
	logic strap_high;
	wire logic scl;
	wire logic host_oe;
	wire logic sda;
	wire logic dut_o;
	wire logic dut_oe;
	wire logic bus_idle;
	wire logic dut2_o;
	wire logic dut2_oe;
	wire logic bus_idle2;
	icdac_drive_s [`ICDAC_NUM_CH-1:0] drive;
	icdac_drive_s [`ICDAC_NUM_CH-1:0] drive2;
	int n_errors = 0;
	int n_tests = 0;
	logic ack;
	logic [7:0] rdat;
	logic [7:0] vals [4] = '{8'haa, 8'h7f, 8'h80, 8'h01};
	// Open-drain wire with pull-up
	assign sda = ~host_oe & (~dut_oe | dut_o) & (~dut2_oe | dut2_o);
	icdac_ctrl #(.FOUR_CH(1'b1)) DUT
	(
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_i(sda),
		.o_sda_o(dut_o), .o_sda_oe(dut_oe),
		.i_addr_strap_low(strap_low), .i_addr_strap_high(strap_high),
		.o_drive(drive), .o_bus_idle(bus_idle)
	);
	// Two-channel build on the same bus, straps inverted so addresses never collide
	icdac_ctrl #(.FOUR_CH(1'b0)) DUT2
	(
		.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda_i(sda),
		.o_sda_o(dut2_o), .o_sda_oe(dut2_oe),
		.i_addr_strap_low(~strap_low), .i_addr_strap_high(~strap_high),
		.o_drive(drive2), .o_bus_idle(bus_idle2)
	);
	icdac_host_model u_host
	(
		.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe)
	);
	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic [8:0] exp_drv(input logic [7:0] v);
		return {~v[7] & |v[6:0], v[7] & |v[6:0], v[6:0]};
	endfunction
	// No stop at the end, so a following read uses a repeated start
	task automatic wr(input logic [7:0] a, input logic [7:0] loc, input logic [7:0] d,
		input logic na);
		u_host.bus_start();
		u_host.put_byte(a, ack);
		chk("addr ack", {8'h00, na}, {8'h00, ack});
		u_host.put_byte(loc, ack);
		chk("loc ack", {8'h00, na}, {8'h00, ack});
		u_host.put_byte(d, ack);
		chk("data ack", {8'h00, na}, {8'h00, ack});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		u_host.bus_start();
		u_host.put_byte(a | 8'h01, ack);
		chk("rd addr ack", 9'h000, {8'h00, ack});
		u_host.get_byte(1'b1, rdat);
		u_host.bus_stop();
		chk("read", {1'b0, exp}, {1'b0, rdat});
		chk("idle", 9'h001, {8'h00, bus_idle});
	endtask
	// Cuts a hang short
	initial
	begin
		#2000000;
		n_errors++;
		complete_run();
	end
	initial
	begin
		i_rst_b = 1'b0;
		strap_low = 1'b0;
		strap_high = 1'b0;
		repeat (20) @(negedge i_mclk);
		i_rst_b = 1'b1;
		repeat (6) @(negedge i_mclk);
		for (int i = 0; i < 4; i++)
			chk("reset drive", 9'h000, drive[i]);
		rd(8'h20, 8'h00);
		// Every strap setting, one channel each
		for (int i = 0; i < 4; i++)
		begin
			{strap_high, strap_low} = 2'(i);
			repeat (6) @(negedge i_mclk);
			wr(8'h20 | 8'(i << 6), 8'hf8 + 8'(i), vals[i], 1'b0);
			chk("drive", exp_drv(vals[i]), drive[i]);
			rd(8'h20 | 8'(i << 6), vals[i]);
		end
		// Foreign address: nothing acknowledged or stored
		wr(8'h40, 8'hf8, 8'h55, 1'b1);
		u_host.bus_stop();
		chk("foreign", exp_drv(vals[0]), drive[0]);
		// Unimplemented location: acknowledged, dropped, reads zero
		wr(8'he0, 8'hf0, 8'h33, 1'b0);
		rd(8'he0, 8'h00);
		chk("unused", exp_drv(vals[0]), drive[0]);
		// Two-channel build: upper locations acknowledge but hold nothing
		wr(8'h20, 8'hfa, 8'h11, 1'b0);
		rd(8'h20, 8'h00);
		chk("two-ch drive", 9'h000, drive2[2]);
		wr(8'h20, 8'hf9, 8'h85, 1'b0);
		rd(8'h20, 8'h85);
		chk("two-ch ch1", exp_drv(8'h85), drive2[1]);
		chk("idle2", 9'h001, {8'h00, bus_idle2});
		// Byte cut short by a stop leaves the setting alone
		u_host.bus_start();
		u_host.put_byte(8'he0, ack);
		u_host.put_byte(8'hf8, ack);
		for (int i = 0; i < 4; i++)
			u_host.put_bit(1'b0, ack);
		u_host.bus_stop();
		chk("partial", exp_drv(vals[0]), drive[0]);
		// Reset in mid-run clears every written setting again
		i_rst_b = 1'b0;
		repeat (4) @(negedge i_mclk);
		i_rst_b = 1'b1;
		repeat (6) @(negedge i_mclk);
		for (int i = 0; i < 4; i++)
			chk("rerun drive", 9'h000, drive[i]);
		chk("rerun drive2", 9'h000, drive2[1]);
		rd(8'he0, 8'h00);
		complete_run();
	end
endmodule // icdac_ctrl_tb
bind icdac_ctrl icdac_ctrl_asserts u_chk
(
	.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda_i(i_sda_i),
	.o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_addr_strap_low(i_addr_strap_low),
	.i_addr_strap_high(i_addr_strap_high), .o_drive(o_drive), .o_bus_idle(o_bus_idle)
);
`default_nettype wire
